//--- hw/scan_cfg_pkg.sv
// Purpose: Shared constants and types for the configuration scan control block
// Assumes: Instruction and scheme pin codes are local choices
// Notes: Register offsets are byte addresses on APB
package scan_cfg_pkg;

	// ==========================================
	// Scan instruction register
	localparam int IR_LEN = 10;
	localparam logic [IR_LEN-1:0] IR_CAPTURE = 10'h001;
	localparam logic [IR_LEN-1:0] INSTR_BYPASS = 10'h3ff;
	localparam logic [IR_LEN-1:0] INSTR_CTRL_RELEASE = 10'h2d0;
	localparam logic [IR_LEN-1:0] INSTR_CTRL_REJOIN = 10'h2b0;
	localparam logic [IR_LEN-1:0] INSTR_PULSE_RECONFIG = 10'h001;
	localparam logic [IR_LEN-1:0] INSTR_USER_CLOCK_SEL = 10'h1ee;
	localparam logic [IR_LEN-1:0] INSTR_OSC_CLOCK_RESTORE = 10'h2ee;
	localparam logic [IR_LEN-1:0] INSTR_FLASH_START_ADDR = 10'h027;

	// ==========================================
	// Configuration scheme select pin codes
	localparam int SCHEME_W = 4;
	localparam logic [SCHEME_W-1:0] SEL_PASSIVE_SERIAL = 4'h0;
	localparam logic [SCHEME_W-1:0] SEL_FAST_PASSIVE = 4'h1;
	localparam logic [SCHEME_W-1:0] SEL_SERIAL_ACTIVE = 4'h2;
	localparam logic [SCHEME_W-1:0] SEL_PARALLEL_ACTIVE = 4'h3;

	typedef enum logic [1:0] {
		passive_serial_scheme = 2'h0,
		fast_passive_parallel_scheme = 2'h1,
		serial_active_scheme = 2'h2,
		parallel_active_scheme = 2'h3
	} scheme_t;

	// ==========================================
	// Boot address
	localparam int BOOT_W = 22;
	localparam int FLASH_ADDR_W = BOOT_W + 2;
	localparam logic [BOOT_W-1:0] BOOT_ADDR_RESET = 22'h000000;
	localparam logic [FLASH_ADDR_W-1:0] NON_FACTORY_ADDR = 24'h000000;

	// ==========================================
	// APB register map
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_BOOT_ADDR = 8'h08;
	localparam int CTRL_REMOTE_UPDATE_BIT = 0;
	localparam int ST_SERIAL_RELEASED_BIT = 0;
	localparam int ST_PARALLEL_RELEASED_BIT = 1;
	localparam int ST_USER_CLOCK_BIT = 2;
	localparam int ST_PIN_DISABLED_BIT = 3;
	localparam int ST_SCHEME_LSB = 4;
	localparam logic CTRL_RESET = 1'b0;

	// ==========================================
	// Test state machine, Gray codes in the order listed, not along every scan path step
	typedef enum logic [3:0] {
		tap_reset = 4'h0,
		tap_idle = 4'h1,
		tap_sel_dr = 4'h3,
		tap_cap_dr = 4'h2,
		tap_shift_dr = 4'h6,
		tap_exit1_dr = 4'h7,
		tap_pause_dr = 4'h5,
		tap_exit2_dr = 4'h4,
		tap_upd_dr = 4'hc,
		tap_sel_ir = 4'hd,
		tap_cap_ir = 4'hf,
		tap_shift_ir = 4'he,
		tap_exit1_ir = 4'ha,
		tap_pause_ir = 4'hb,
		tap_exit2_ir = 4'h9,
		tap_upd_ir = 4'h8
	} tap_state_t;

endpackage

//--- hw/tap_state_machine.sv
// Purpose: Test access port state machine stepped by sampled clock rises
// Assumes: tck_rise is a one-cycle pulse in the pclk domain
// Notes: All sixteen codes are used, so no default branch
module tap_state_machine
	import scan_cfg_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tck_rise,
	input wire logic tms,
	output tap_state_t state
);

	// ==========================================
	// Next state
	tap_state_t next_state;

	always_comb begin
		next_state = state;
		unique case (state)
			tap_reset: next_state = tms ? tap_reset : tap_idle;
			tap_idle: next_state = tms ? tap_sel_dr : tap_idle;
			tap_sel_dr: next_state = tms ? tap_sel_ir : tap_cap_dr;
			tap_cap_dr: next_state = tms ? tap_exit1_dr : tap_shift_dr;
			tap_shift_dr: next_state = tms ? tap_exit1_dr : tap_shift_dr;
			tap_exit1_dr: next_state = tms ? tap_upd_dr : tap_pause_dr;
			tap_pause_dr: next_state = tms ? tap_exit2_dr : tap_pause_dr;
			tap_exit2_dr: next_state = tms ? tap_upd_dr : tap_shift_dr;
			tap_upd_dr: next_state = tms ? tap_sel_dr : tap_idle;
			tap_sel_ir: next_state = tms ? tap_reset : tap_cap_ir;
			tap_cap_ir: next_state = tms ? tap_exit1_ir : tap_shift_ir;
			tap_shift_ir: next_state = tms ? tap_exit1_ir : tap_shift_ir;
			tap_exit1_ir: next_state = tms ? tap_upd_ir : tap_pause_ir;
			tap_pause_ir: next_state = tms ? tap_exit2_ir : tap_pause_ir;
			tap_exit2_ir: next_state = tms ? tap_upd_ir : tap_shift_ir;
			tap_upd_ir: next_state = tms ? tap_sel_dr : tap_idle;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= tap_reset;
		end else if (tck_rise) begin
			state <= next_state;
		end
	end

endmodule

//--- hw/active_config_scan_control.sv
// Purpose: Scan instruction control around the active configuration controllers
// Assumes: Scan pins are sampled by pclk, far faster than the test clock
// Notes: presetn doubles as the power-on reset of the device
//
// Function
// R01: Release instruction idles the active controller
// R02: Scheme pins pick serial or parallel controller
// R03: Host releases before scan programming in active schemes
// R04: Release under passive scheme changes nothing
// R05: Serial held idle, parallel sent chill-out
// R06: User mode re-engages released controller
// R07: Serial rejoins on test reset or rejoin
// R08: Parallel rejoins only on rejoin; pin never
// R09: Rejoin anytime, re-engages and starts reconfiguration
// R10: Rejoin under passive acts as pulse reconfigure
// R11: Rejoin disables the reconfiguration request pin
// R12: Host issues instructions in the strict order
// R13: Host avoids I/O reconfiguration at power up
// R14: Controllers default to internal oscillator clock
// R15: User clock select persists across instructions
// R16: Only restore instruction or power-on clears select
// R17: Pin toggle or test reset keep clock
// R18: Address instruction links data through 22-bit shifter
// R19: Shifted address loads 22-bit update register
// R20: Update register captured and shifted out
// R21: Two zero bits appended below boot address
// R22: Remote update: address applies to factory only
// R23: Update register loads on update-data state
//
// Chosen here: register access over APB and the register addresses.
module active_config_scan_control
	import scan_cfg_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	input wire logic [SCHEME_W-1:0] scheme_select_pins,
	input wire logic reconfig_request_n,
	input wire logic user_mode,
	input wire logic image_is_factory,
	output logic serial_ctrl_idle,
	output logic parallel_ctrl_chill_out,
	output logic ctrl_reengage,
	output logic ctrl_enter_user_mode,
	output logic start_reconfig,
	output logic reconfig_pin_disabled,
	output logic user_clock_select,
	output logic [FLASH_ADDR_W-1:0] flash_start_address
);

	// ==========================================
	// Functions
	function automatic scheme_t decode_scheme(input logic [SCHEME_W-1:0] pins);
		scheme_t s;
		s = passive_serial_scheme;
		if (pins == SEL_SERIAL_ACTIVE) begin
			s = serial_active_scheme;
		end else if (pins == SEL_PARALLEL_ACTIVE) begin
			s = parallel_active_scheme;
		end else if (pins == SEL_FAST_PASSIVE) begin
			s = fast_passive_parallel_scheme;
		end
		return s;
	endfunction

	// ==========================================
	// Pin synchronisers
	// A third stage on the test clock only feeds edge detection, never the first stage
	logic [2:0] tck_sync;
	logic [1:0] tms_sync, tdi_sync, reconfig_sync;
	logic reconfig_prev;
	logic [SCHEME_W-1:0] scheme_meta;
	logic [SCHEME_W-1:0] scheme_pins;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tck_sync <= 3'h0;
			tms_sync <= 2'h3;
			tdi_sync <= 2'h0;
			reconfig_sync <= 2'h3;
			reconfig_prev <= 1'b1;
			scheme_meta <= SEL_PASSIVE_SERIAL;
			scheme_pins <= SEL_PASSIVE_SERIAL;
		end else begin
			tck_sync <= {tck_sync[1:0], tck};
			tms_sync <= {tms_sync[0], tms};
			tdi_sync <= {tdi_sync[0], tdi};
			reconfig_sync <= {reconfig_sync[0], reconfig_request_n};
			reconfig_prev <= reconfig_sync[1];
			scheme_meta <= scheme_select_pins;
			scheme_pins <= scheme_meta;
		end
	end

	logic tck_rise, tck_fall, pin_reconfig_fall;
	scheme_t scheme;

	assign tck_rise = tck_sync[1] & ~tck_sync[2];
	assign tck_fall = ~tck_sync[1] & tck_sync[2];
	assign pin_reconfig_fall = reconfig_prev & ~reconfig_sync[1];
	assign scheme = decode_scheme(scheme_pins); // R02

	// ==========================================
	// Test state machine
	tap_state_t tap_state;

	tap_state_machine u_tap (
		.pclk(pclk),
		.presetn(presetn),
		.tck_rise(tck_rise),
		.tms(tms_sync[1]),
		.state(tap_state)
	);

	logic step, enter_tap_reset, ir_updated;

	assign step = tck_rise;
	assign enter_tap_reset = step && tap_state == tap_sel_ir && tms_sync[1];
	assign ir_updated = step && tap_state == tap_upd_ir;

	// ==========================================
	// Instruction register
	logic [IR_LEN-1:0] ir_shift;
	logic [IR_LEN-1:0] instr;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ir_shift <= IR_CAPTURE;
		end else if (step && tap_state == tap_cap_ir) begin
			ir_shift <= IR_CAPTURE;
		end else if (step && tap_state == tap_shift_ir) begin
			ir_shift <= {tdi_sync[1], ir_shift[IR_LEN-1:1]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr <= INSTR_BYPASS;
		end else if (step && tap_state == tap_reset) begin
			instr <= INSTR_BYPASS;
		end else if (ir_updated) begin
			instr <= ir_shift;
		end
	end

	logic new_release, new_rejoin, new_pulse, new_user_clock, new_osc_restore;

	assign new_release = ir_updated && ir_shift == INSTR_CTRL_RELEASE;
	assign new_rejoin = ir_updated && ir_shift == INSTR_CTRL_REJOIN;
	assign new_pulse = ir_updated && ir_shift == INSTR_PULSE_RECONFIG;
	assign new_user_clock = ir_updated && ir_shift == INSTR_USER_CLOCK_SEL;
	assign new_osc_restore = ir_updated && ir_shift == INSTR_OSC_CLOCK_RESTORE;

	// ==========================================
	// Data registers
	logic addr_selected, bypass_bit;
	logic [BOOT_W-1:0] boot_shift, boot_addr;

	assign addr_selected = instr == INSTR_FLASH_START_ADDR; // R18

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_shift <= BOOT_ADDR_RESET;
		end else if (step && addr_selected && tap_state == tap_cap_dr) begin
			boot_shift <= boot_addr; // R20
		end else if (step && addr_selected && tap_state == tap_shift_dr) begin
			boot_shift <= {tdi_sync[1], boot_shift[BOOT_W-1:1]}; // R18
		end
	end

	// Never reset by the test reset state, only by power-on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_addr <= BOOT_ADDR_RESET;
		end else if (step && addr_selected && tap_state == tap_upd_dr) begin
			boot_addr <= boot_shift; // R19 R23
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bypass_bit <= 1'b0;
		end else if (step && tap_state == tap_cap_dr) begin
			bypass_bit <= 1'b0;
		end else if (step && tap_state == tap_shift_dr) begin
			bypass_bit <= tdi_sync[1];
		end
	end

	// ==========================================
	// Test data output, changes on the falling test clock
	logic next_tdo;

	always_comb begin
		next_tdo = bypass_bit;
		if (tap_state == tap_shift_ir) begin
			next_tdo = ir_shift[0];
		end else if (addr_selected) begin
			next_tdo = boot_shift[0]; // R20
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else if (tck_fall) begin
			tdo <= next_tdo;
			tdo_oe <= tap_state == tap_shift_ir || tap_state == tap_shift_dr;
		end
	end

	// ==========================================
	// Controller release and re-engage
	logic user_mode_prev, user_mode_rise, serial_released, parallel_released;

	assign user_mode_rise = user_mode & ~user_mode_prev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			user_mode_prev <= 1'b0;
		end else begin
			user_mode_prev <= user_mode;
		end
	end

	// Release under a passive scheme leaves both flags alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_released <= 1'b0;
		end else if (new_release && scheme == serial_active_scheme) begin
			serial_released <= 1'b1; // R01 R04 R05
		end else if (user_mode_rise || new_rejoin || enter_tap_reset) begin
			serial_released <= 1'b0; // R06 R07
		end
	end

	// The request pin plays no part here, so it cannot re-engage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			parallel_released <= 1'b0;
		end else if (new_release && scheme == parallel_active_scheme) begin
			parallel_released <= 1'b1; // R01 R04 R05
		end else if (user_mode_rise || new_rejoin) begin
			parallel_released <= 1'b0; // R06 R08
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reengage <= 1'b0;
			ctrl_enter_user_mode <= 1'b0;
		end else begin
			ctrl_reengage <= (serial_released && (new_rejoin || enter_tap_reset)) ||
				(parallel_released && new_rejoin); // R07 R08 R09
			ctrl_enter_user_mode <= user_mode_rise && (serial_released || parallel_released); // R06
		end
	end

	assign serial_ctrl_idle = serial_released;
	assign parallel_ctrl_chill_out = parallel_released;

	// ==========================================
	// Reconfiguration requests
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reconfig_pin_disabled <= 1'b0;
		end else if (new_rejoin) begin
			reconfig_pin_disabled <= 1'b1; // R11
		end else if (user_mode_rise) begin
			reconfig_pin_disabled <= 1'b0;
		end
	end

	// Rejoin restarts in any scheme; under passive it equals the pulse instruction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_reconfig <= 1'b0;
		end else begin
			start_reconfig <= new_rejoin || new_pulse ||
				(pin_reconfig_fall && !reconfig_pin_disabled); // R09 R10 R11
		end
	end

	// ==========================================
	// Active clock source
	// Only power-on or the restore instruction clears the select; pin toggles and test resets are ignored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			user_clock_select <= 1'b0; // R14 R16
		end else if (new_user_clock) begin
			user_clock_select <= 1'b1; // R15
		end else if (new_osc_restore) begin
			user_clock_select <= 1'b0; // R16 R17
		end
	end

	// ==========================================
	// Flash start address
	logic remote_update_en;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_start_address <= NON_FACTORY_ADDR;
		end else if (remote_update_en && !image_is_factory) begin
			flash_start_address <= NON_FACTORY_ADDR; // R22
		end else begin
			flash_start_address <= {boot_addr, 2'b00}; // R21
		end
	end

	// ==========================================
	// APB slave, zero wait states
	logic apb_write, apb_setup, addr_known;
	logic [31:0] next_prdata;

	assign apb_write = psel && penable && pwrite;
	assign apb_setup = psel && !penable;
	assign addr_known = paddr == OFS_CONTROL || paddr == OFS_STATUS || paddr == OFS_BOOT_ADDR;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_known;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remote_update_en <= CTRL_RESET;
		end else if (apb_write && paddr == OFS_CONTROL) begin
			remote_update_en <= pwdata[CTRL_REMOTE_UPDATE_BIT];
		end
	end

	always_comb begin
		next_prdata = 32'h00000000;
		if (paddr == OFS_CONTROL) begin
			next_prdata[CTRL_REMOTE_UPDATE_BIT] = remote_update_en;
		end else if (paddr == OFS_STATUS) begin
			next_prdata[ST_SERIAL_RELEASED_BIT] = serial_released;
			next_prdata[ST_PARALLEL_RELEASED_BIT] = parallel_released;
			next_prdata[ST_USER_CLOCK_BIT] = user_clock_select;
			next_prdata[ST_PIN_DISABLED_BIT] = reconfig_pin_disabled;
			next_prdata[ST_SCHEME_LSB +: 2] = scheme;
		end else if (paddr == OFS_BOOT_ADDR) begin
			next_prdata[BOOT_W-1:0] = boot_addr;
		end
	end

	// Data is sampled in the setup cycle so it is steady through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (apb_setup) begin
			prdata <= next_prdata;
		end
	end

endmodule

//--- tb/scan_ctl_sva.sv
// Purpose: Port-level checks for the configuration scan control block
// Assumes: tck stands still between scan frames
// Notes: A quiet window means tck unchanged for 15 pclk cycles
module scan_ctl_sva
	import scan_cfg_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tck,
	input wire logic user_mode,
	input wire logic reconfig_request_n,
	input wire logic [SCHEME_W-1:0] scheme_select_pins,
	input wire logic serial_ctrl_idle,
	input wire logic parallel_ctrl_chill_out,
	input wire logic ctrl_enter_user_mode,
	input wire logic start_reconfig,
	input wire logic reconfig_pin_disabled,
	input wire logic user_clock_select,
	input wire logic [FLASH_ADDR_W-1:0] flash_start_address
);
	// ==========================================
	// Quiet window tracking
	logic tck_q;
	logic [3:0] calm;
	logic quiet;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tck_q <= 1'b0;
			calm <= 4'h0;
		end else begin
			tck_q <= tck;
			if (tck != tck_q)
				calm <= 4'h0;
			else if (calm != 4'hf)
				calm <= calm + 4'h1;
		end
	end
	assign quiet = calm == 4'hf;

	// ==========================================
	// Properties
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_low_zero; flash_start_address[1:0] == 2'b00; endproperty
	a_low_zero: assert property (p_low_zero) else $error("flash address low bits not zero");
	property p_serial_src; $rose(serial_ctrl_idle) |-> scheme_select_pins == SEL_SERIAL_ACTIVE; endproperty
	a_serial_src: assert property (p_serial_src) else $error("serial idle outside serial scheme");
	property p_par_src; $rose(parallel_ctrl_chill_out) |-> scheme_select_pins == SEL_PARALLEL_ACTIVE; endproperty
	a_par_src: assert property (p_par_src) else $error("chill-out outside parallel scheme");
	property p_one_owner; !(serial_ctrl_idle && parallel_ctrl_chill_out); endproperty
	a_one_owner: assert property (p_one_owner) else $error("both controllers released");
	property p_user; $rose(user_mode) && (serial_ctrl_idle || parallel_ctrl_chill_out) |-> ##[1:3] ctrl_enter_user_mode;
	endproperty
	a_user: assert property (p_user) else $error("no re-engage on user mode");
	property p_keep_clk; quiet |-> $stable(user_clock_select); endproperty
	a_keep_clk: assert property (p_keep_clk) else $error("clock source moved without scan");
	property p_keep_rel; quiet && !user_mode && !$past(user_mode) |-> $stable(serial_ctrl_idle) && $stable(parallel_ctrl_chill_out);
	endproperty
	a_keep_rel: assert property (p_keep_rel) else $error("release state moved without scan");
	property p_blocked; quiet && reconfig_pin_disabled |-> !start_reconfig; endproperty
	a_blocked: assert property (p_blocked) else $error("disabled pin started reconfiguration");
	property p_pin_go; quiet && !reconfig_pin_disabled && $fell(reconfig_request_n) |-> ##[2:8] start_reconfig;
	endproperty
	a_pin_go: assert property (p_pin_go) else $error("enabled pin did not reconfigure");
endmodule

bind active_config_scan_control scan_ctl_sva i_scan_ctl_sva (.pclk, .presetn, .tck, .user_mode, .reconfig_request_n,
	.scheme_select_pins, .serial_ctrl_idle, .parallel_ctrl_chill_out, .ctrl_enter_user_mode, .start_reconfig,
	.reconfig_pin_disabled, .user_clock_select, .flash_start_address);

//--- tb/scan_host.sv
// Purpose: Behavioural scan host driving the test access port
// Assumes: Caller starts a frame from Run-Test-Idle
// Notes: tck stands low between frames; tdi flips when released
module scan_host (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// ==========================================
	// One tck period; tdo sampled just before the rise
	task automatic tick(input logic m, input logic d, output logic v);
		tms = m;
		tdi = d;
		#62.5;
		v = tdo;
		tck = 1'b1;
		#62.5;
		tck = 1'b0;
	endtask
	// Full IR or DR pass, LSB first, ending in Idle
	task automatic scan(input logic ir, input logic [21:0] din, input int n, output logic [21:0] dout);
		logic v;
		dout = '0;
		tick(1'b1, 1'b0, v);
		if (ir)
			tick(1'b1, 1'b0, v);
		tick(1'b0, 1'b0, v);
		tick(1'b0, 1'b0, v);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], v);
			dout[i] = v;
		end
		tick(1'b1, 1'b0, v);
		tick(1'b0, 1'b0, v);
		tdi = ~tdi;
	endtask
	// Idle to reset through Select-IR, back to Idle
	task automatic tap_reset;
		logic v;
		repeat (3) tick(1'b1, 1'b0, v);
		tick(1'b0, 1'b0, v);
	endtask
	// Release precedes programming; strict order; no I/O reconfig at power up
endmodule

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the configuration scan control block
// Assumes: Scheme pins settle four pclk cycles before use
// Notes: Pulse outputs are counted and checked as snapshots
module tb_top
	import scan_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tck, tms, tdi, tdo, tdo_oe;
	logic reconfig_request_n, user_mode, image_is_factory, serial_ctrl_idle, parallel_ctrl_chill_out;
	logic ctrl_reengage, ctrl_enter_user_mode, start_reconfig, reconfig_pin_disabled, user_clock_select, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] scheme_select_pins;
	logic [3:0] n_reeng = 4'h0, n_start = 4'h0, n_user = 4'h0, b_reeng = 4'h0, b_start = 4'h0, b_user = 4'h0;
	logic oe_seen = 1'b0;
	logic [FLASH_ADDR_W-1:0] flash_start_address;
	logic [21:0] so;
	logic [15:0] rel_e [4] = '{16'h0000, 16'h0000, 16'h8000, 16'h4000};
	logic [15:0] rej_e [4] = '{16'h2010, 16'h2010, 16'h2110, 16'h2110};
	int n_fail, num_checks;
	active_config_scan_control i_active_config_scan_control (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .tck, .tms, .tdi, .tdo, .tdo_oe, .scheme_select_pins,
		.reconfig_request_n, .user_mode, .image_is_factory, .serial_ctrl_idle, .parallel_ctrl_chill_out,
		.ctrl_reengage, .ctrl_enter_user_mode, .start_reconfig, .reconfig_pin_disabled, .user_clock_select,
		.flash_start_address);
	scan_host host (.tck, .tms, .tdi, .tdo);
	always #2 pclk = ~pclk;
	always @(posedge pclk) begin
		n_reeng <= n_reeng + {3'h0, ctrl_reengage === 1'b1};
		n_start <= n_start + {3'h0, start_reconfig === 1'b1};
		n_user <= n_user + {3'h0, ctrl_enter_user_mode === 1'b1};
		oe_seen <= oe_seen | (tdo_oe === 1'b1);
	end
	// ==========================================
	// Bench tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	// Flags and pulse counts since the last snapshot
	task automatic obs(input logic [15:0] e);
		@(negedge pclk);
		chk({16'h0, serial_ctrl_idle, parallel_ctrl_chill_out, reconfig_pin_disabled, user_clock_select,
			4'(n_reeng - b_reeng), 4'(n_start - b_start), 4'(n_user - b_user)}, {16'h0, e});
		{b_reeng, b_start, b_user} = {n_reeng, n_start, n_user};
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			n_fail++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic instr(input logic [IR_LEN-1:0] c);
		host.scan(1'b1, {12'h0, c}, IR_LEN, so);
	endtask
	task automatic setp(input logic [3:0] v);
		@(posedge pclk);
		scheme_select_pins <= v;
		repeat (4) @(posedge pclk);
	endtask
	// Long enough both ways for the pin synchroniser and edge detect
	task automatic pin;
		repeat (20) @(posedge pclk);
		reconfig_request_n <= 1'b0;
		repeat (20) @(posedge pclk);
		reconfig_request_n <= 1'b1;
		repeat (20) @(posedge pclk);
	endtask
	task automatic umode;
		@(posedge pclk);
		user_mode <= 1'b1;
		repeat (8) @(posedge pclk);
		user_mode <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask
	task automatic print_verdict;
		if (n_fail == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Watchdog well beyond the expected run of roughly 44 us
	initial begin
		#300000;
		n_fail++;
		print_verdict();
	end
	// ==========================================
	// Tests
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata, user_mode} = '0;
		{reconfig_request_n, image_is_factory} = 2'b11;
		scheme_select_pins = SEL_SERIAL_ACTIVE;
		{n_fail, num_checks} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		host.tap_reset();
		obs(16'h0000);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h20);
		apb(1'b0, 8'h0c, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		for (int s = 0; s < 4; s++) begin
			setp(s[3:0]);
			instr(INSTR_CTRL_RELEASE);
			obs(rel_e[s]);
			instr(INSTR_CTRL_REJOIN);
			obs(rej_e[s]);
			umode();
			obs(16'h0000);
		end
		setp(SEL_SERIAL_ACTIVE);
		instr(INSTR_CTRL_RELEASE);
		host.tap_reset();
		obs(16'h0100);
		setp(SEL_PARALLEL_ACTIVE);
		instr(INSTR_CTRL_RELEASE);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h32);
		host.tap_reset();
		pin();
		obs(16'h4010);
		umode();
		obs(16'h0001);
		instr(INSTR_USER_CLOCK_SEL);
		obs(16'h1000);
		instr(INSTR_BYPASS);
		host.tap_reset();
		pin();
		obs(16'h1010);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h34);
		instr(INSTR_OSC_CLOCK_RESTORE);
		obs(16'h0000);
		instr(INSTR_PULSE_RECONFIG);
		obs(16'h0010);
		instr(INSTR_CTRL_REJOIN);
		pin();
		obs(16'h2010);
		umode();
		instr(INSTR_FLASH_START_ADDR);
		host.scan(1'b0, 22'h2a5c3b, BOOT_W, so);
		chk(so, BOOT_ADDR_RESET);
		chk(flash_start_address, {22'h2a5c3b, 2'b00});
		host.scan(1'b0, 22'h15a3c4, BOOT_W, so);
		chk(so, 22'h2a5c3b);
		chk({oe_seen, tdo_oe}, 32'h2);
		apb(1'b0, OFS_BOOT_ADDR, 32'h0);
		chk(rd, 32'h15a3c4);
		apb(1'b1, OFS_CONTROL, 32'h1);
		image_is_factory <= 1'b0;
		apb(1'b0, OFS_CONTROL, 32'h0);
		chk({rd[30:0], flash_start_address == NON_FACTORY_ADDR}, 32'h3);
		image_is_factory <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(flash_start_address, {22'h15a3c4, 2'b00});
		instr(INSTR_USER_CLOCK_SEL);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk(user_clock_select, 1'b0);
		print_verdict();
	end
endmodule
